// file: pkg/lcc_params.svh
// constants of the logic cell control block: offsets, fields, resets
// assumes a 100 MHz core clock and a 4-bit AXI4-Lite byte address
//
// Functional notes
// RQ1 - each gate invert bit (19..16) inverts its channel before the cell.
// RQ2 - the enable bit (15) lets the cell combine; cleared, all outputs are 0; the code still drives cell_pin_oe from bit 7.
// RQ3 - bit 11 set flags an interrupt on each low-to-high cell output edge.
// RQ4 - bit 10 set flags an interrupt on each high-to-low cell output edge.
// RQ5 - software should not enable rising and falling interrupts together.
// RQ6 - the pin output enable (bit 7) routes the cell output to its pin.
// RQ7 - bit 6 is read-only and shows the present cell output level.
// RQ8 - bits 31..20, 14..12, 9..8, 4 and 3 ignore writes and read as zero.
// RQ9 - every control field, mode included, is zero after reset.
// RQ10 - the output invert bit (5) inverts the final output before use.
// RQ11 - edges are sampled on the core clock and flagged within one cycle.
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

`define LCC_OFS_CTRL 4'h0
`define LCC_OFS_STS 4'h4
`define LCC_OFS_MASK 4'h8

`define LCC_B_GINV_LO 16
`define LCC_B_GINV_HI 19
`define LCC_B_ON 15
`define LCC_B_RISE_EN 11
`define LCC_B_FALL_EN 10
`define LCC_B_OE 7
`define LCC_B_OUT 6
`define LCC_B_POL 5
`define LCC_B_MODE_HI 2
`define LCC_B_MODE_LO 0

`define LCC_CTRL_WMASK 32'h000f8ca7
`define LCC_CTRL_RST 32'h00000000
`define LCC_STS_RST 2'h0
`define LCC_MASK_RST 2'h0
`define LCC_S_RISE 0
`define LCC_S_FALL 1

`define LCC_MODE_OR 3'h0
`define LCC_MODE_AND 3'h1
`define LCC_MODE_XOR 3'h2
`define LCC_MODE_AO 3'h3
`define LCC_MODE_NOR 3'h4

`define LCC_RESP_OKAY 2'h0
`define LCC_RESP_SLVERR 2'h2

`endif

// file: pkg/lcc_pkg.sv
// types of the logic cell control block
// assumes lcc_params.svh for the numeric constants
package lcc_pkg;
  typedef logic [2:0] lcc_mode_t;
  typedef logic [3:0] lcc_addr_t;
  typedef enum logic [1:0] {
    LCC_SEL_CTRL,
    LCC_SEL_STS,
    LCC_SEL_MASK,
    LCC_SEL_NONE
  } lcc_sel_e;
endpackage

// file: src/lcc_sync.sv
// two-flop synchroniser for the four channel inputs
// assumes the inputs are asynchronous to core_clk
`timescale 1ns/1ps
module lcc_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  import lcc_pkg::*;
  logic [3:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// file: src/lcc_cell.sv
// gate inversion and combining function of the logic cell
// assumes synchronised channel inputs and registered control fields
`timescale 1ns/1ps
`include "lcc_params.svh"
module lcc_cell (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] chan,
  input wire logic [3:0] gate_invert,
  input wire logic cell_enable,
  input wire lcc_pkg::lcc_mode_t mode,
  output logic cell_out_r
);
  import lcc_pkg::*;
  logic [3:0] gated;
  logic cell_nxt;

  // per-channel inversion before the cell [RQ1]
  assign gated = chan ^ gate_invert;

  always_comb begin
    case (mode)
      `LCC_MODE_OR: cell_nxt = |gated;
      `LCC_MODE_AND: cell_nxt = &gated;
      `LCC_MODE_XOR: cell_nxt = ^gated;
      `LCC_MODE_AO: cell_nxt = (gated[0] & gated[1]) | (gated[2] & gated[3]);
      `LCC_MODE_NOR: cell_nxt = ~(|gated);
      default: cell_nxt = |gated;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cell_out_r <= 1'b0;
    end else begin
      // disabled cell gives logic zero [RQ2]
      cell_out_r <= cell_enable & cell_nxt;
    end
  end
endmodule

// file: src/lcc_top.sv
// logic cell control: AXI4-Lite registers, cell, edge interrupts, pin
// assumes channel inputs arrive from pins, asynchronous to core_clk
`timescale 1ns/1ps
`include "lcc_params.svh"
module lcc_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire lcc_pkg::lcc_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire lcc_pkg::lcc_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] chan_in,
  output logic cell_pin_out,
  output logic cell_pin_oe,
  output logic irq
);
  import lcc_pkg::*;

  logic [3:0] chan_sync;
  logic cell_raw;
  logic [31:0] ctrl_r;
  logic [1:0] sts_r;
  logic [1:0] mask_r;
  logic final_r;
  logic prev_r;
  lcc_addr_t aw_addr_r;
  logic aw_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_full_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic irq_r;
  logic pin_out_r;
  logic pin_oe_r;
  logic [3:0] ginv;
  logic cell_on;
  logic rise_en;
  logic fall_en;
  logic pin_en;
  logic out_inv;
  lcc_mode_t mode;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  lcc_sel_e wr_sel;
  lcc_sel_e rd_sel;
  logic rise_evt;
  logic fall_evt;
  logic [1:0] sts_set;
  logic sts_clr;
  logic [31:0] ctrl_view;

  function automatic lcc_sel_e reg_sel(input lcc_addr_t a);
    lcc_addr_t w;
    w = {a[3:2], 2'b00};
    case (w)
      `LCC_OFS_CTRL: reg_sel = LCC_SEL_CTRL;
      `LCC_OFS_STS: reg_sel = LCC_SEL_STS;
      `LCC_OFS_MASK: reg_sel = LCC_SEL_MASK;
      default: reg_sel = LCC_SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lane_merge = (old_v & ~m) | (new_v & m);
  endfunction

  assign ginv = ctrl_r[`LCC_B_GINV_HI:`LCC_B_GINV_LO];
  assign cell_on = ctrl_r[`LCC_B_ON];
  assign rise_en = ctrl_r[`LCC_B_RISE_EN];
  assign fall_en = ctrl_r[`LCC_B_FALL_EN];
  assign pin_en = ctrl_r[`LCC_B_OE];
  assign out_inv = ctrl_r[`LCC_B_POL];
  assign mode = ctrl_r[`LCC_B_MODE_HI:`LCC_B_MODE_LO];

  lcc_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in(chan_in),
    .sync_out(chan_sync)
  );

  lcc_cell u_cell (
    .core_clk(core_clk),
    .rstn(rstn),
    .chan(chan_sync),
    .gate_invert(ginv),
    .cell_enable(cell_on),
    .mode(mode),
    .cell_out_r(cell_raw)
  );

  // final output with optional inversion, zero while disabled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      final_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      final_r <= cell_on & (cell_raw ^ out_inv); // [RQ10] [RQ2]
      prev_r <= final_r; // [RQ11]
    end
  end

  // pin drive
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_out_r <= final_r & pin_en; // [RQ6]
      pin_oe_r <= pin_en; // [RQ6]
    end
  end

  // edge events
  assign rise_evt = final_r & ~prev_r & rise_en; // [RQ3] [RQ11]
  assign fall_evt = ~final_r & prev_r & fall_en; // [RQ4] [RQ11]
  assign sts_set = {fall_evt, rise_evt};

  // bus handshakes
  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs = s_axi_wvalid & wready_r;
  assign ar_hs = s_axi_arvalid & arready_r;
  assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_sel = reg_sel(aw_addr_r);
  assign rd_sel = reg_sel(s_axi_araddr);
  assign sts_clr = ar_hs & (rd_sel == LCC_SEL_STS);

  // sticky status, set wins over read clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sts_r <= `LCC_STS_RST;
    end else begin
      sts_r <= sts_set | (sts_r & {2{~sts_clr}}); // [RQ3] [RQ4]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sts_r & mask_r);
    end
  end

  // control and mask registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `LCC_CTRL_RST; // [RQ9]
      mask_r <= `LCC_MASK_RST;
    end else if (do_wr) begin
      if (wr_sel == LCC_SEL_CTRL) begin
        // unused bits never stored [RQ8]
        ctrl_r <= lane_merge(ctrl_r, w_data_r, w_strb_r) & `LCC_CTRL_WMASK;
      end
      if (wr_sel == LCC_SEL_MASK && w_strb_r[0]) begin
        mask_r <= w_data_r[1:0];
      end
    end
  end

  // write address and data capture, either order
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_addr_r <= 4'h0;
      aw_full_r <= 1'b0;
      awready_r <= 1'b1;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      w_full_r <= 1'b0;
      wready_r <= 1'b1;
    end else begin
      if (aw_hs) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
        awready_r <= 1'b1;
      end
      if (w_hs) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
        wready_r <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `LCC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_sel == LCC_SEL_NONE) ? `LCC_RESP_SLVERR : `LCC_RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // control register view with the live output status
  always_comb begin
    ctrl_view = ctrl_r;
    ctrl_view[`LCC_B_OUT] = final_r; // [RQ7]
  end

  // read channel
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `LCC_RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= `LCC_RESP_OKAY;
      case (rd_sel)
        LCC_SEL_CTRL: rdata_r <= ctrl_view; // [RQ7] [RQ8]
        LCC_SEL_STS: rdata_r <= {30'h0, sts_r};
        LCC_SEL_MASK: rdata_r <= {30'h0, mask_r};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= `LCC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign cell_pin_out = pin_out_r;
  assign cell_pin_oe = pin_oe_r;
  assign irq = irq_r;

  // checks
  lcc_sel_e rd_sel_r;
  logic rd_out_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_sel_r <= LCC_SEL_NONE;
      rd_out_r <= 1'b0;
    end else if (ar_hs) begin
      rd_sel_r <= rd_sel;
      rd_out_r <= final_r;
    end
  end

  property p_gate_invert;
    @(posedge core_clk) disable iff (!rstn)
    cell_on && mode == `LCC_MODE_AND && ginv == 4'hf && chan_sync == 4'h0
      |=> cell_raw;
  endproperty
  a_gate_invert: assert property (p_gate_invert) // [RQ1]
    else $error("inverted gates did not reach the cell");

  property p_disabled_zero;
    @(posedge core_clk) disable iff (!rstn)
    !cell_on |=> !cell_raw && !final_r;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) // [RQ2]
    else $error("disabled cell output not zero");

  property p_rise_flag;
    @(posedge core_clk) disable iff (!rstn)
    final_r && !prev_r && rise_en |=> sts_r[`LCC_S_RISE];
  endproperty
  a_rise_flag: assert property (p_rise_flag) // [RQ3]
    else $error("rising edge not flagged");

  property p_fall_flag;
    @(posedge core_clk) disable iff (!rstn)
    !final_r && prev_r && fall_en |=> sts_r[`LCC_S_FALL];
  endproperty
  a_fall_flag: assert property (p_fall_flag) // [RQ4]
    else $error("falling edge not flagged");

  property p_rise_cause;
    @(posedge core_clk) disable iff (!rstn)
    $rose(sts_r[`LCC_S_RISE]) |-> $past(rise_en) && $past(final_r)
      && !$past(prev_r);
  endproperty
  a_rise_cause: assert property (p_rise_cause) // [RQ3]
    else $error("rise flag set without an enabled edge");

  property p_pin_off;
    @(posedge core_clk) disable iff (!rstn)
    !pin_en |=> !cell_pin_oe && !cell_pin_out;
  endproperty
  a_pin_off: assert property (p_pin_off) // [RQ6]
    else $error("pin driven while disabled");

  property p_status_read;
    @(posedge core_clk) disable iff (!rstn)
    rvalid_r && rd_sel_r == LCC_SEL_CTRL
      |-> s_axi_rdata[`LCC_B_OUT] == rd_out_r;
  endproperty
  a_status_read: assert property (p_status_read) // [RQ7]
    else $error("output status bit wrong");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rstn)
    rvalid_r && rd_sel_r == LCC_SEL_CTRL
      |-> (s_axi_rdata & 32'hfff07318) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RQ8]
    else $error("unused control bits not zero");

  property p_out_invert;
    @(posedge core_clk) disable iff (!rstn)
    cell_on && out_inv |=> final_r == !$past(cell_raw);
  endproperty
  a_out_invert: assert property (p_out_invert) // [RQ10]
    else $error("output inversion wrong");

  property p_irq_level;
    @(posedge core_clk) disable iff (!rstn)
    (sts_r & mask_r) != 2'h0 |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not raised");

  c_rise_flag: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(sts_r[`LCC_S_RISE]));
  c_fall_flag: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(sts_r[`LCC_S_FALL]));
  c_write_done: cover property (@(posedge core_clk) disable iff (!rstn)
    bvalid_r && s_axi_bready);
  c_irq: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(irq));
endmodule

// file: verif/tb_lcc_top.sv
// testbench of the logic cell control block: register bus, cell, irq, pin
// assumes lcc_top as declared, a 100 MHz core clock and async low reset
`timescale 1ns/1ps
`include "lcc_params.svh"
module tb_lcc_top;
  import lcc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  lcc_addr_t awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  lcc_addr_t araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [3:0] chan = '0;
  logic pin_out;
  logic pin_oe;
  logic irq;
  int error_cnt = 0;
  int checks_done = 0;

  always #5 core_clk = ~core_clk;

  lcc_top i_dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .chan_in(chan),
    .cell_pin_out(pin_out),
    .cell_pin_oe(pin_oe),
    .irq(irq)
  );

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic timed_out();
    error_cnt++;
    $display("Error at %0t: bus answer never came", $time);
    final_report();
  endtask

  task automatic wr_chk(input lcc_addr_t a, input logic [31:0] d,
                        input logic [1:0] er, input string what);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 100) timed_out();
    chk({30'h0, bresp}, {30'h0, er}, what);
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input lcc_addr_t a, input logic [31:0] exp,
                        input logic [1:0] er, input string what);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 100) timed_out();
    chk(rdata, exp, what);
    chk({30'h0, rresp}, {30'h0, er}, what);
    rready <= 1'b0;
  endtask

  // channel input to pin and status takes five edges, irq one more
  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask

  function automatic logic cell_f(input int m, input logic [3:0] g);
    case (m)
      1: return &g;
      2: return ^g;
      3: return (g[0] & g[1]) | (g[2] & g[3]);
      4: return ~|g;
      default: return |g;
    endcase
  endfunction

  initial begin
    logic [31:0] ctl;
    logic e;
    logic [3:0] g;
    int m;
    int p;
    int k;
    int iv;
    logic [3:0] pats [5];
    pats = '{4'h0, 4'h1, 4'h3, 4'h6, 4'hf};
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd_chk(`LCC_OFS_CTRL, 32'h0, 2'h0, "ctrl reset");
    rd_chk(`LCC_OFS_STS, 32'h0, 2'h0, "status reset");
    rd_chk(`LCC_OFS_MASK, 32'h0, 2'h0, "mask reset");
    chk({29'h0, irq, pin_out, pin_oe}, 32'h0, "pins reset");
    // all but edge enables: inverted zeros give 1, output invert gives 0
    wr_chk(`LCC_OFS_CTRL, 32'hfffff3ff, 2'h0, "ctrl write");
    settle();
    rd_chk(`LCC_OFS_CTRL, 32'h000f80a7, 2'h0, "unused bits");
    chk({30'h0, pin_oe, pin_out}, 32'h2, "pin all ones");
    wr_chk(4'hc, 32'hffffffff, 2'h2, "unmapped write");
    rd_chk(4'hc, 32'h0, 2'h2, "unmapped read");
    for (m = 0; m < 5; m++) begin
      for (iv = 0; iv < 16; iv += 5) begin
        for (p = 0; p < 2; p++) begin
          for (k = 0; k < 5; k++) begin
            ctl = {12'h0, 4'(iv), 8'h80, 2'b10, 1'(p), 2'b00, 3'(m)};
            chan <= pats[k];
            wr_chk(`LCC_OFS_CTRL, ctl, 2'h0, "ctrl mode");
            settle();
            g = pats[k] ^ 4'(iv);
            e = cell_f(m, g) ^ 1'(p);
            chk({31'h0, pin_out}, {31'h0, e}, "cell pin");
            rd_chk(`LCC_OFS_CTRL, ctl | {25'h0, e, 6'h0}, 2'h0,
                   "cell status");
          end
        end
      end
    end
    chan <= 4'hf;
    wr_chk(`LCC_OFS_CTRL, 32'h000000a0, 2'h0, "disable");
    settle();
    chk({31'h0, pin_out}, 32'h0, "disabled pin");
    rd_chk(`LCC_OFS_CTRL, 32'h000000a0, 2'h0, "disabled out");
    chan <= 4'h1;
    wr_chk(`LCC_OFS_CTRL, 32'h00008000, 2'h0, "pin off");
    settle();
    chk({30'h0, pin_oe, pin_out}, 32'h0, "pin disabled");
    rd_chk(`LCC_OFS_CTRL, 32'h00008040, 2'h0, "status pin off");
    wr_chk(`LCC_OFS_MASK, 32'h3, 2'h0, "mask write");
    rd_chk(`LCC_OFS_MASK, 32'h3, 2'h0, "mask stored");
    chan <= 4'h0;
    wr_chk(`LCC_OFS_CTRL, 32'h00008800, 2'h0, "rise enable");
    settle();
    rd_chk(`LCC_OFS_CTRL, 32'h00008800, 2'h0, "rise stored");
    rd_chk(`LCC_OFS_STS, 32'h0, 2'h0, "status idle");
    chan <= 4'h1;
    settle();
    chk({31'h0, irq}, 32'h1, "rise irq");
    chan <= 4'h0;
    settle();
    rd_chk(`LCC_OFS_STS, 32'h1, 2'h0, "rise only");
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    wr_chk(`LCC_OFS_CTRL, 32'h00008400, 2'h0, "fall enable");
    chan <= 4'h1;
    settle();
    rd_chk(`LCC_OFS_STS, 32'h0, 2'h0, "rise ignored");
    rd_chk(`LCC_OFS_CTRL, 32'h00008440, 2'h0, "fall stored");
    chan <= 4'h0;
    settle();
    chk({31'h0, irq}, 32'h1, "fall irq");
    wr_chk(`LCC_OFS_MASK, 32'h0, 2'h0, "mask off");
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd_chk(`LCC_OFS_STS, 32'h2, 2'h0, "fall status");
    final_report();
  end
endmodule
